// *** hdl/sfc_device.sv ***
// Serial flash command front end, device end of the SPI link.
// Assumes link pins are asynchronous to clk_in and much slower than it.
`timescale 1ns/1ps
module sfc_device
  import sfc_pkg::*;
(
  input  wire logic               clk_in,
  input  wire logic               rst_in,
  sfc_link_if.dev                 link,
  output logic [ADDR_W-1:0]       mem_addr_out,
  input  wire logic [7:0]         mem_data_in,
  output logic [7:0]              cmd_op_out,
  output logic [ADDR_W-1:0]       cmd_addr_out,
  output logic                    cmd_done_out
);
  logic [2:0]        cs_sync_q, sck_sync_q;
  logic [1:0]        si_sync_q;
  sfc_phase_e        phase_q;
  logic [7:0]        shift_q;
  logic [2:0]        bit_q;
  logic [1:0]        byte_q;
  logic [7:0]        op_q;
  logic [ADDR_W-1:0] addr_q;
  logic [7:0]        out_q;
  logic              so_q;
  logic              oe_q;
  logic              args_ok_q;

  function automatic logic op_has_addr(input logic [7:0] op);
    return op == OP_READ_FAST || op == OP_READ_SLOW || op == OP_ERASE_4K ||
           op == OP_ERASE_32K || op == OP_ERASE_64K || op == OP_PAGE_PROG ||
           op == OP_PROTECT || op == OP_UNPROTECT || op == OP_RD_PROT;
  endfunction

  function automatic logic op_known(input logic [7:0] op);
    return op_has_addr(op) || op == OP_CHIP_ERASE_A || op == OP_CHIP_ERASE_B ||
           op == OP_WR_EN || op == OP_WR_DIS || op == OP_RD_STATUS ||
           op == OP_WR_STATUS || op == OP_RD_ID || op == OP_POWER_DOWN ||
           op == OP_RESUME;
  endfunction

  // pins pass two flops before use; stage 2 vs 3 finds edges
  wire cs_act   = ~cs_sync_q[1];
  // Release edge, not level, so each command is reported once
  wire cs_rise  = cs_sync_q[1] & ~cs_sync_q[2];
  // sample on rising link clock edge, shift out on falling
  // edges found by transition, so idle level does not matter
  wire sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
  wire sck_fall = ~sck_sync_q[1] & sck_sync_q[2];
  // shift in most significant bit first
  wire [7:0] byte_in  = {shift_q[6:0], si_sync_q[1]};
  wire       byte_end = bit_q == 3'h7;
  wire       is_read  = op_q == OP_READ_FAST || op_q == OP_READ_SLOW;

  assign link.so_o  = so_q;
  assign link.so_oe = oe_q;
  assign mem_addr_out = addr_q;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cs_sync_q  <= 3'h7;
      sck_sync_q <= 3'h0;
      si_sync_q  <= 2'h0;
    end
    else
    begin
      cs_sync_q  <= {cs_sync_q[1:0], link.cs_n};
      sck_sync_q <= {sck_sync_q[1:0], link.sck};
      si_sync_q  <= {si_sync_q[0], link.si};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      phase_q      <= SFC_OPCODE;
      shift_q      <= 8'h00;
      bit_q        <= 3'h0;
      byte_q       <= 2'h0;
      op_q         <= 8'h00;
      addr_q       <= '0;
      out_q        <= 8'h00;
      so_q         <= 1'b0;
      oe_q         <= 1'b0;
      args_ok_q    <= 1'b0;
      cmd_op_out   <= 8'h00;
      cmd_addr_out <= '0;
      cmd_done_out <= 1'b0;
    end
    else
    begin
      cmd_done_out <= 1'b0;
      if (!cs_act)
      begin
        // release ends operation; output off at once
        // Counters cleared so the next frame starts at its opcode
        oe_q    <= 1'b0;
        phase_q <= SFC_OPCODE;
        bit_q   <= 3'h0;
        byte_q  <= 2'h0;
        // report only commands whose framing was complete
        if (cs_rise && args_ok_q)
        begin
          cmd_op_out   <= op_q;
          cmd_addr_out <= addr_q;
          cmd_done_out <= 1'b1;
        end
        args_ok_q <= 1'b0;
      end
      else
      begin
        if (sck_rise && phase_q != SFC_IGNORE)
        begin
          shift_q <= byte_in;
          bit_q   <= bit_q + 3'h1;
        end
        if (sck_rise && byte_end)
        begin
          unique case (phase_q)
            SFC_OPCODE:
            begin
              op_q <= byte_in;
              if (!op_known(byte_in))
                phase_q <= SFC_IGNORE;
              else if (op_has_addr(byte_in))
                phase_q <= SFC_ADDR;
              else
              begin
                phase_q   <= SFC_ARGS;
                args_ok_q <= 1'b1;
              end
            end
            SFC_ADDR:
            begin
              addr_q <= {addr_q[ADDR_W-9:0], byte_in};
              byte_q <= byte_q + 2'h1;
              if (byte_q == ADDR_BYTES - 2'h1)
              begin
                args_ok_q <= 1'b1;
                // fast read adds one dummy byte
                if (op_q == OP_READ_FAST)
                  phase_q <= SFC_DUMMY;
                else if (is_read)
                  phase_q <= SFC_DATA_OUT;
                else
                  phase_q <= SFC_ARGS;
              end
            end
            SFC_DUMMY: phase_q <= SFC_DATA_OUT;
            // advance after each full byte; wraps at top
            SFC_DATA_OUT: addr_q <= addr_q + 22'h1;
            SFC_ARGS: phase_q <= SFC_ARGS;
            SFC_IGNORE: phase_q <= SFC_IGNORE;
          endcase
        end
        // Bit 0 fetches a fresh byte; the address moved on at the last rise
        // drive data on falling edges, MSB first
        if (sck_fall && phase_q == SFC_DATA_OUT)
        begin
          oe_q <= 1'b1;
          if (bit_q == 3'h0)
          begin
            so_q  <= mem_data_in[7];
            out_q <= {mem_data_in[6:0], 1'b0};
          end
          else
          begin
            so_q  <= out_q[7];
            out_q <= {out_q[6:0], 1'b0};
          end
        end
        else if (phase_q != SFC_DATA_OUT)
          oe_q <= 1'b0;
      end
    end
  end
endmodule

// *** hdl/sfc_pkg.sv ***
// Shared constants for the serial flash command front end.
// Assumes both ends run from one 100 MHz system clock.
package sfc_pkg;
  localparam int unsigned CLK_PERIOD_NS   = 10;
  // Link clock period of the host, in ns; HALF_CYC below is its half period in system cycles
  localparam int unsigned LINK_PERIOD_NS  = 80;
  localparam int unsigned HALF_CYC        = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int unsigned ADDR_W          = 22;
  localparam logic [21:0] ADDR_LAST       = 22'h3fffff;
  localparam logic [7:0]  OP_READ_FAST    = 8'h0b;
  localparam logic [7:0]  OP_READ_SLOW    = 8'h03;
  localparam logic [7:0]  OP_ERASE_4K     = 8'h20;
  localparam logic [7:0]  OP_ERASE_32K    = 8'h52;
  localparam logic [7:0]  OP_ERASE_64K    = 8'hd8;
  localparam logic [7:0]  OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0]  OP_CHIP_ERASE_B = 8'hc7;
  localparam logic [7:0]  OP_PAGE_PROG    = 8'h02;
  localparam logic [7:0]  OP_WR_EN        = 8'h06;
  localparam logic [7:0]  OP_WR_DIS       = 8'h04;
  localparam logic [7:0]  OP_PROTECT      = 8'h36;
  localparam logic [7:0]  OP_UNPROTECT    = 8'h39;
  localparam logic [7:0]  OP_RD_PROT      = 8'h3c;
  localparam logic [7:0]  OP_RD_STATUS    = 8'h05;
  localparam logic [7:0]  OP_WR_STATUS    = 8'h01;
  localparam logic [7:0]  OP_RD_ID        = 8'h9f;
  localparam logic [7:0]  OP_POWER_DOWN   = 8'hb9;
  localparam logic [7:0]  OP_RESUME       = 8'hab;
  // Address byte count of every command that takes an address
  localparam logic [1:0]  ADDR_BYTES      = 2'h3;
  typedef enum logic [2:0] {
    SFC_OPCODE, SFC_ADDR, SFC_DUMMY, SFC_DATA_OUT, SFC_ARGS, SFC_IGNORE
  } sfc_phase_e;
endpackage

// *** hdl/sfc_link_if.sv ***
// SPI link between host and flash front end.
// Resolves the serial output wire from the device enable.
`timescale 1ns/1ps
interface sfc_link_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so_o;
  logic so_oe;
  wire  so;
  // Released line shows the inverse of the last bit, so a late enable is caught
  assign so = so_oe ? so_o : ~so_o;
  modport host (output cs_n, output sck, output si, input so);
  modport dev  (input cs_n, input sck, input si, output so_o, output so_oe);
endinterface

// *** hdl/sfc_host.sv ***
// SPI master end of the serial flash link.
// Drives mode 0; link clock made by dividing clk_in.
`timescale 1ns/1ps
module sfc_host
  import sfc_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  sfc_link_if.host         link,
  input  wire logic        start_in,
  input  wire logic [7:0]  tx_data_in,
  input  wire logic        last_in,
  output logic             tx_take_out,
  output logic [7:0]       rx_data_out,
  output logic             rx_valid_out,
  output logic             busy_out
);
  logic [7:0] div_q;
  logic       active_q, sck_q, cs_n_q, si_q;
  logic [7:0] tx_q, rx_q;
  logic [2:0] bit_q;
  logic       last_q;
  logic [1:0] so_sync_q;

  wire half = div_q == 8'(HALF_CYC - 1);
  wire [7:0] rx_next = {rx_q[6:0], so_sync_q[1]};

  assign link.cs_n = cs_n_q;
  assign link.sck  = sck_q;
  assign link.si   = si_q;

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      div_q        <= 8'h00;
      active_q     <= 1'b0;
      sck_q        <= 1'b0;
      cs_n_q       <= 1'b1;
      si_q         <= 1'b0;
      tx_q         <= 8'h00;
      rx_q         <= 8'h00;
      bit_q        <= 3'h0;
      last_q       <= 1'b0;
      so_sync_q    <= 2'h0;
      tx_take_out  <= 1'b0;
      rx_data_out  <= 8'h00;
      rx_valid_out <= 1'b0;
      busy_out     <= 1'b0;
    end
    else
    begin
      so_sync_q    <= {so_sync_q[0], link.so};
      tx_take_out  <= 1'b0;
      rx_valid_out <= 1'b0;
      div_q        <= half ? 8'h00 : div_q + 8'h1;
      if (!active_q)
      begin
        if (start_in)
        begin
          active_q    <= 1'b1;
          busy_out    <= 1'b1;
          cs_n_q      <= 1'b0;
          si_q        <= tx_data_in[7];
          tx_q        <= {tx_data_in[6:0], 1'b0};
          last_q      <= last_in;
          bit_q       <= 3'h0;
          tx_take_out <= 1'b1;
          div_q       <= 8'h00;
        end
      end
      else if (half)
      begin
        sck_q <= ~sck_q;
        // Sample on the falling edge: the synchronisers on both sides
        // make the round trip longer than half a link period
        if (sck_q)
          rx_q <= rx_next;
        if (sck_q && bit_q == 3'h7)
        begin
          rx_data_out  <= rx_next;
          rx_valid_out <= 1'b1;
          bit_q        <= 3'h0;
          // select released after the final byte
          if (last_q)
          begin
            active_q <= 1'b0;
            busy_out <= 1'b0;
            cs_n_q   <= 1'b1;
          end
          else
          begin
            si_q        <= tx_data_in[7];
            tx_q        <= {tx_data_in[6:0], 1'b0};
            last_q      <= last_in;
            tx_take_out <= 1'b1;
          end
        end
        else if (sck_q)
        begin
          bit_q <= bit_q + 3'h1;
          si_q  <= tx_q[7];
          tx_q  <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end
endmodule

// *** tb/sfc_link_assertions.sv ***
// Checks on the link wires between host and device ends.
// Assumes a mode 0 host with 4-cycle link half periods.
`timescale 1ns/1ps
module sfc_link_assertions (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so_o,
  input wire logic so_oe
);
  logic       sck_q;
  logic [2:0] bit_q;
  logic [2:0] bit_d;
  logic [3:0] tot_q;
  logic [3:0] tot_d;
  wire        rise = sck && !sck_q;
  assign bit_d = cs_n ? 3'h0 : bit_q + {2'h0, rise};
  assign tot_d = cs_n ? 4'h0 : (rise && !tot_q[3]) ? tot_q + 4'h1 : tot_q;
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      sck_q <= 1'b0;
      bit_q <= 3'h0;
      tot_q <= 4'h0;
    end
    else
    begin
      sck_q <= sck;
      bit_q <= bit_d;
      tot_q <= tot_d;
    end
  end
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  sequence s_high_half;
    sck [*4] ##1 !sck;
  endsequence
  sequence s_off_stays;
    !so_oe [*4];
  endsequence
  AST_SCK_IDLE: assert property (cs_n |-> !sck)
    else $error("link clock not low while deselected");
  AST_SCK_IN_FRAME: assert property ($rose(sck) |-> !cs_n)
    else $error("link clock edge outside a frame");
  AST_HALF_PERIOD: assert property ($rose(sck) |-> s_high_half)
    else $error("link clock high half not four cycles");
  AST_SI_ON_LOW: assert property ($changed(si) && !cs_n |-> !sck)
    else $error("host data changed while clock high");
  AST_SO_ON_LOW: assert property (so_oe && $changed(so_o) |-> !sck)
    else $error("device data changed while clock high");
  AST_SO_OFF_RELEASE: assert property ($rose(cs_n) |-> ##3 s_off_stays)
    else $error("output still driven after release");
  AST_SO_OFF_IDLE: assert property (cs_n [*4] |-> !so_oe)
    else $error("output driven while deselected");
  AST_BYTE_END: assert property ($rose(cs_n) |-> bit_q == 3'h0)
    else $error("frame ended off a byte boundary");
  AST_OE_AFTER_BYTE: assert property ($rose(so_oe) |-> bit_q == 3'h0 && tot_q[3])
    else $error("output enabled inside a byte");
  AST_SELECT_LOW: assert property ($fell(cs_n) |-> !sck [*2])
    else $error("clock not low at select");
endmodule

// *** tb/tb_top.sv ***
// Testbench joining host and device ends across one link interface.
// Assumes a combinational array model on the device read port.
`timescale 1ns/1ps
`define CHK(g, e, m) \
  begin \
    checked++; \
    if ((g) !== (e)) \
    begin \
      num_errors++; \
      $display("wrong value at %0t: %s", $time, m); \
    end \
  end
module tb_top
  import sfc_pkg::*;
;
  localparam logic [7:0] OPS [16] = '{OP_ERASE_4K, OP_ERASE_32K, OP_ERASE_64K,
    OP_PAGE_PROG, OP_PROTECT, OP_UNPROTECT, OP_RD_PROT, OP_CHIP_ERASE_A, OP_CHIP_ERASE_B,
    OP_WR_EN, OP_WR_DIS, OP_RD_STATUS, OP_WR_STATUS, OP_RD_ID, OP_POWER_DOWN, OP_RESUME};
  logic              clk_in;
  logic              rst_in;
  logic              start;
  logic [7:0]        tx_data;
  logic              last;
  logic              tx_take;
  logic [7:0]        rx_data;
  logic              rx_valid;
  logic              busy;
  logic [ADDR_W-1:0] mem_addr;
  logic [7:0]        mem_data;
  logic [7:0]        cmd_op;
  logic [ADDR_W-1:0] cmd_addr;
  logic              cmd_done;
  logic [7:0]        tx_q [$];
  logic [7:0]        rx_q [$];
  int                num_errors = 0;
  int                checked = 0;
  int                cycles = 0;
  int                done_cnt = 0;
  int                base;
  // Array content depends on the low and high address bytes, so a wrap is visible
  assign mem_data = mem_addr[7:0] + mem_addr[21:14];
  sfc_link_if link ();
  sfc_host u_sfc_host (.clk_in(clk_in), .rst_in(rst_in), .link(link), .start_in(start),
    .tx_data_in(tx_data), .last_in(last), .tx_take_out(tx_take), .rx_data_out(rx_data),
    .rx_valid_out(rx_valid), .busy_out(busy));
  sfc_device u_sfc_device (.clk_in(clk_in), .rst_in(rst_in), .link(link),
    .mem_addr_out(mem_addr), .mem_data_in(mem_data), .cmd_op_out(cmd_op),
    .cmd_addr_out(cmd_addr), .cmd_done_out(cmd_done));
  sfc_link_assertions u_sfc_link_assertions (.clk_in(clk_in), .rst_in(rst_in),
    .cs_n(link.cs_n), .sck(link.sck), .si(link.si), .so_o(link.so_o), .so_oe(link.so_oe));
  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in)
  begin
    cycles++;
    if (cmd_done === 1'b1)
      done_cnt++;
    if (cycles == 30000)
    begin
      num_errors++;
      summarize();
    end
  end
  task automatic summarize();
    if (num_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // one whole frame, next byte handed over after each take
  task automatic frame();
    int i;
    int n;
    i = 0;
    n = 0;
    rx_q.delete();
    @(posedge clk_in);
    start <= 1'b1;
    tx_data <= tx_q[0];
    last <= (tx_q.size() == 1);
    do
    begin
      @(posedge clk_in);
      n++;
      if (busy === 1'b1)
        start <= 1'b0;
      if (rx_valid === 1'b1)
        rx_q.push_back(rx_data);
      if (tx_take === 1'b1)
      begin
        i++;
        tx_data <= tx_q[i % tx_q.size()];
        last <= (i == tx_q.size() - 1);
      end
    end
    while (n < 3000 && !(i > 0 && busy === 1'b0));
    // A frame that never ends counts as a mismatch
    if (n >= 3000)
    begin
      num_errors++;
      summarize();
    end
    repeat (8) @(posedge clk_in);
  endtask
  task automatic chk_stream(input int first, input int cnt, input logic [ADDR_W-1:0] a);
    for (int k = 0; k < cnt; k++)
    begin
      `CHK(rx_q[first + k], mem_byte(a), "read data")
      a = a + 22'h1;
    end
  endtask
  function automatic logic [7:0] mem_byte(input logic [ADDR_W-1:0] a);
    return a[7:0] + a[21:14];
  endfunction
  initial
  begin
    rst_in = 1'b1;
    start = 1'b0;
    tx_data = 8'h00;
    last = 1'b0;
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    tx_q = {8'hff, OP_ERASE_4K, 8'h00, 8'h00};
    base = done_cnt;
    frame();
    `CHK(done_cnt, base, "unknown opcode acted on")
    tx_q = {OP_ERASE_4K, 8'h12, 8'h34};
    frame();
    `CHK(done_cnt, base, "partial address acted on")
    tx_q = {OP_READ_FAST, 8'hff, 8'hff, 8'hfe, 8'h00, 8'h00, 8'h00, 8'h00};
    frame();
    chk_stream(5, 3, 22'h3ffffe);
    tx_q = {OP_READ_SLOW, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00};
    frame();
    chk_stream(4, 2, 22'h000100);
    for (int j = 0; j < $size(OPS); j++)
    begin
      if (j < 7)
        tx_q = {OPS[j], 8'hc1, 8'h23, 8'h45, 8'h00};
      else
        tx_q = {OPS[j], 8'h00};
      base = done_cnt;
      frame();
      `CHK(done_cnt, base + 1, "command not reported")
      `CHK(cmd_op, OPS[j], "opcode mismatch")
      if (j < 7)
        `CHK(cmd_addr, 22'h012345, "address mismatch")
    end
    summarize();
  end
endmodule
